// >>> core/copm_pkg.sv
// Purpose: Shared constants and types for the clock-output pin and MAC pad mux block.
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register.
// Notes: Printed offsets are register indices; byte address is four times the index.
// Functional notes
// - Control bit 15 set: second indicator pin becomes transmit-error input, driver off.
// - Bit 8 set with clock function: output selected clock divided by two.
// - Source field bits 7-4, codes 0-7 pick the first eight internal clocks.
// - Source codes 8-14 pick interface, RMII, serdes, tick and DLL clocks.
// - Bit 3 set with clock function: invert the selected clock.
// - Function field bits 2-0 chooses what drives the clock-output pin.
// - Daisy-chain strap on second indicator pin forces function field to zero.
// - Bits 15-14 hold receive pin pull: none, up, down, reserved.
// - Bit 13 enables pull override on receive MAC pins.
// - Bits 12-11 hold transmit pin pull: none, up, down, reserved.
// - Bit 10 enables pull override on transmit MAC pins.
// - Bits 9-5 receive pad impedance code, read/write, reset zero.
// - Bits 4-0 transmit pad impedance code, read/write, reset zero.
// - Pad pull and impedance register at 456h, resets to zero.
// - Pin input status register at 457h, sixteen-bit read-only, resets zero.
// - Status bits report live pin levels while inputs forced; bit 12 reads zero.
`default_nettype none

package copm_pkg;
   localparam logic [11:0] IDX_CLK_CFG = 12'h453;
   localparam logic [11:0] IDX_PAD_CFG = 12'h456;
   localparam logic [11:0] IDX_PIN_STAT = 12'h457;
   localparam logic [15:0] PAD_CFG_RST = 16'h0000;
   localparam logic [15:0] CLK_CFG_WMASK = 16'h81FF;
   localparam int CLK_TXER_BIT = 15;
   localparam int CLK_DIV2_BIT = 8;
   localparam int CLK_SRC_LSB = 4;
   localparam int CLK_INV_BIT = 3;
   localparam int RX_PULL_LSB = 14;
   localparam int RX_OVR_BIT = 13;
   localparam int TX_PULL_LSB = 11;
   localparam int TX_OVR_BIT = 10;
   localparam int RX_IMP_LSB = 5;
   localparam int TX_IMP_LSB = 0;
   localparam int STAT_ZERO_BIT = 12;
   localparam logic [2:0] FUNC_RST_STRAP = 3'h0;
   localparam logic [2:0] FUNC_RST_NORM = 3'h1;
   localparam logic [3:0] SRC_UNDEF = 4'hF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      FN_INDICATOR2,
      FN_CLOCK,
      FN_WAKE,
      FN_UNDERVOLT,
      FN_PTP_TX,
      FN_PTP_RX,
      FN_ESD,
      FN_IRQ
   } copm_func_t;

   typedef enum logic [1:0] {
      PULL_NONE,
      PULL_UP,
      PULL_DOWN,
      PULL_RSVD
   } copm_pull_t;

   typedef struct packed {
      logic txer_in;
      logic div2;
      logic [3:0] src;
      logic inv;
      copm_func_t func;
   } copm_clkcfg_t;

   typedef struct packed {
      logic pull_up;
      logic pull_down;
   } copm_pad_pull_t;
endpackage

`default_nettype wire

// >>> core/copm_clk_path.sv
// Purpose: Selects, divides and inverts one of fifteen internal clocks.
// Assumes: Source clocks are sampled as ordinary inputs of aclk.
// Notes: Divider toggles on rising edges of the selected source.
`default_nettype none

module copm_clk_path (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [14:0] src_clks,
   input wire logic [3:0] src_sel,
   input wire logic div2_en,
   input wire logic inv_en,
   output logic clk_out
);
   logic sel_w;
   logic sel_d_r;
   logic half_r;
   logic pre_w;
   logic out_r;

   // Undefined code gives a steady low
   assign sel_w = (src_sel == copm_pkg::SRC_UNDEF) ? 1'b0 : src_clks[src_sel];
   assign pre_w = div2_en ? half_r : sel_w;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_d_r <= 1'b0;
         half_r <= 1'b0;
         out_r <= 1'b0;
      end else if (ce) begin
         sel_d_r <= sel_w;
         if (sel_w && !sel_d_r) begin
            half_r <= ~half_r;
         end
         out_r <= (src_sel == copm_pkg::SRC_UNDEF) ? 1'b0 : (pre_w ^ inv_en);
      end
   end

   assign clk_out = out_r;
endmodule

`default_nettype wire

// >>> core/copm_top.sv
// Purpose: Clock-output pin mux, indicator2 direction and MAC pad pull/impedance control.
// Assumes: AXI4-Lite slave, 12-bit index space, strap inputs valid during reset.
// Notes: Boot strap level is caught on the clock while reset is held; daisy strap acts every cycle.
`default_nettype none

module copm_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [13:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [13:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic receive_bit3_boot_strap,
   input wire logic indicator2_daisy_strap,
   input wire logic [14:0] src_clks,
   input wire logic indicator2_func,
   input wire logic wake_frame_indicator,
   input wire logic undervolt_flag,
   input wire logic ptp_tx_event,
   input wire logic ptp_rx_event,
   input wire logic esd_event,
   input wire logic irq_level,
   input wire logic pins_input_forced,
   input wire logic [15:0] pin_levels,
   input wire logic indicator2_in,
   output logic clkout_pin,
   output logic indicator2_out,
   output logic indicator2_oe_n,
   output logic transmit_error_input,
   output logic rx_pull_up,
   output logic rx_pull_down,
   output logic tx_pull_up,
   output logic tx_pull_down,
   output logic [4:0] rx_impedance,
   output logic [4:0] tx_impedance
);
   copm_pkg::copm_clkcfg_t clk_cfg_r;
   logic [15:0] pad_cfg_r;
   logic [15:0] stat_r;
   logic aw_full_r;
   logic w_full_r;
   logic [11:0] aw_idx_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r;
   logic bvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic rvalid_r;
   logic clk_path_w;
   logic pin_nxt;
   logic pin_r;
   logic [15:0] clk_rd_w;
   logic [15:0] clk_wr_w;
   logic [15:0] pad_wr_w;
   logic [15:0] wmask_w;
   logic wr_go_w;
   logic wr_clk_w;
   logic wr_pad_w;
   logic wr_hit_w;
   logic [11:0] ar_idx_w;
   logic rd_go_w;
   logic rd_hit_w;
   logic [15:0] rd_val_w;
   copm_pkg::copm_pull_t rx_pull_w;
   copm_pkg::copm_pull_t tx_pull_w;

   // Write channel: address and data latched independently, either order
   assign s_axi_awready = !aw_full_r && !bvalid_r;
   assign s_axi_wready = !w_full_r && !bvalid_r;
   assign wr_go_w = aw_full_r && w_full_r && !bvalid_r;
   assign wr_clk_w = wr_go_w && (aw_idx_r == copm_pkg::IDX_CLK_CFG);
   assign wr_pad_w = wr_go_w && (aw_idx_r == copm_pkg::IDX_PAD_CFG);
   assign wr_hit_w = (aw_idx_r == copm_pkg::IDX_CLK_CFG) || (aw_idx_r == copm_pkg::IDX_PAD_CFG)
      || (aw_idx_r == copm_pkg::IDX_PIN_STAT);
   assign wmask_w = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   // Struct is 10 bits; bits 14-9 of the register are reserved and read zero
   assign clk_rd_w = {clk_cfg_r.txer_in, 6'h00, clk_cfg_r.div2, clk_cfg_r.src, clk_cfg_r.inv, clk_cfg_r.func};
   assign clk_wr_w = (clk_rd_w & ~(wmask_w & copm_pkg::CLK_CFG_WMASK))
      | (wdata_r[15:0] & wmask_w & copm_pkg::CLK_CFG_WMASK);
   assign pad_wr_w = (pad_cfg_r & ~wmask_w) | (wdata_r[15:0] & wmask_w);

   // Read channel: one read in flight, answered the cycle after acceptance
   assign s_axi_arready = !rvalid_r;
   assign rd_go_w = s_axi_arvalid && !rvalid_r;
   assign ar_idx_w = s_axi_araddr[13:2];
   assign rd_hit_w = (ar_idx_w == copm_pkg::IDX_CLK_CFG) || (ar_idx_w == copm_pkg::IDX_PAD_CFG)
      || (ar_idx_w == copm_pkg::IDX_PIN_STAT);
   assign rd_val_w = (ar_idx_w == copm_pkg::IDX_CLK_CFG) ? clk_rd_w :
      (ar_idx_w == copm_pkg::IDX_PAD_CFG) ? pad_cfg_r :
      (ar_idx_w == copm_pkg::IDX_PIN_STAT) ? stat_r : 16'h0000;

   assign s_axi_bresp = bresp_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rvalid = rvalid_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_idx_r <= 12'h000;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= copm_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            aw_idx_r <= s_axi_awaddr[13:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_go_w) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit_w ? copm_pkg::RESP_OKAY : copm_pkg::RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= copm_pkg::RESP_OKAY;
      end else if (ce) begin
         if (rd_go_w) begin
            rvalid_r <= 1'b1;
            rdata_r <= {16'h0000, rd_val_w};
            rresp_r <= rd_hit_w ? copm_pkg::RESP_OKAY : copm_pkg::RESP_SLVERR;
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_cfg_r <= '0;
         clk_cfg_r.func <= copm_pkg::copm_func_t'(receive_bit3_boot_strap ?
            copm_pkg::FUNC_RST_STRAP : copm_pkg::FUNC_RST_NORM);
         pad_cfg_r <= copm_pkg::PAD_CFG_RST;
      end else if (ce) begin
         if (wr_clk_w) begin
            clk_cfg_r <= copm_pkg::copm_clkcfg_t'({clk_wr_w[15], clk_wr_w[8:0]});
         end
         if (indicator2_daisy_strap) begin
            clk_cfg_r.func <= copm_pkg::FN_INDICATOR2;
         end
         if (wr_pad_w) begin
            pad_cfg_r <= pad_wr_w;
         end
      end
   end

   // Status sampled only while direction is forced to input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_r <= 16'h0000;
      end else if (ce) begin
         if (pins_input_forced) begin
            stat_r <= pin_levels & ~(16'h0001 << copm_pkg::STAT_ZERO_BIT);
         end
      end
   end

   copm_clk_path u_clk_path (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .src_clks(src_clks),
      .src_sel(clk_cfg_r.src),
      .div2_en(clk_cfg_r.div2),
      .inv_en(clk_cfg_r.inv),
      .clk_out(clk_path_w)
   );

   // Clock-output pin function select
   always_comb begin
      case (clk_cfg_r.func)
         copm_pkg::FN_INDICATOR2: pin_nxt = indicator2_func;
         copm_pkg::FN_CLOCK: pin_nxt = clk_path_w;
         copm_pkg::FN_WAKE: pin_nxt = wake_frame_indicator;
         copm_pkg::FN_UNDERVOLT: pin_nxt = undervolt_flag;
         copm_pkg::FN_PTP_TX: pin_nxt = ptp_tx_event;
         copm_pkg::FN_PTP_RX: pin_nxt = ptp_rx_event;
         copm_pkg::FN_ESD: pin_nxt = esd_event;
         copm_pkg::FN_IRQ: pin_nxt = irq_level;
         default: pin_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_r <= 1'b0;
      end else if (ce) begin
         pin_r <= pin_nxt;
      end
   end

   assign clkout_pin = pin_r;

   // Second indicator pin turns to an input for transmit error
   assign indicator2_oe_n = clk_cfg_r.txer_in;
   assign indicator2_out = clk_cfg_r.txer_in ? 1'b0 : indicator2_func;
   assign transmit_error_input = clk_cfg_r.txer_in & indicator2_in;

   // Reserved pull code falls back to no pull
   assign rx_pull_w = pad_cfg_r[13] ? copm_pkg::copm_pull_t'(pad_cfg_r[15:14]) : copm_pkg::PULL_NONE;
   assign tx_pull_w = pad_cfg_r[10] ? copm_pkg::copm_pull_t'(pad_cfg_r[12:11]) : copm_pkg::PULL_NONE;
   assign rx_pull_up = (rx_pull_w == copm_pkg::PULL_UP);
   assign rx_pull_down = (rx_pull_w == copm_pkg::PULL_DOWN);
   assign tx_pull_up = (tx_pull_w == copm_pkg::PULL_UP);
   assign tx_pull_down = (tx_pull_w == copm_pkg::PULL_DOWN);
   assign rx_impedance = pad_cfg_r[9:5];
   assign tx_impedance = pad_cfg_r[4:0];
endmodule

`default_nettype wire

// >>> sim/copm_top_sva.sv
// Purpose: Port-level checks for copm_top.
// Assumes: ce held high by the bench.
// Notes: Bound into every copm_top instance.
`default_nettype none

module copm_top_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic indicator2_in,
   input wire logic indicator2_oe_n,
   input wire logic indicator2_out,
   input wire logic transmit_error_input,
   input wire logic clkout_pin,
   input wire logic rx_pull_up,
   input wire logic rx_pull_down,
   input wire logic tx_pull_up,
   input wire logic tx_pull_down
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_txer_input_gate: assert property (transmit_error_input == (indicator2_oe_n & indicator2_in))
      else $error("transmit error input not gated by pin mode");
   a_ind2_released: assert property (indicator2_oe_n |-> !indicator2_out)
      else $error("indicator2 driven while released");
   a_rx_pull_excl: assert property (!(rx_pull_up && rx_pull_down))
      else $error("receive pins pulled both ways");
   a_tx_pull_excl: assert property (!(tx_pull_up && tx_pull_down))
      else $error("transmit pins pulled both ways");
   a_rd_answer_next: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rd_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   a_wr_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   a_rd_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("read upper half not zero");
   a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !clkout_pin && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs active in reset");

   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_txer: cover property (indicator2_oe_n && transmit_error_input);
endmodule

bind copm_top copm_top_sva u_sva (.*);

`default_nettype wire

// >>> sim/copm_top_tb.sv
// Purpose: Self-checking bench for copm_top.
// Assumes: ce held high; sources static except in the divider test.
// Notes: Random data from a fixed seed.
`default_nettype none

module copm_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] CK = copm_pkg::IDX_CLK_CFG;
   localparam logic [11:0] PD = copm_pkg::IDX_PAD_CFG;
   localparam logic [11:0] ST = copm_pkg::IDX_PIN_STAT;
   localparam logic [1:0] OK = copm_pkg::RESP_OKAY;
   logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, receive_bit3_boot_strap, indicator2_daisy_strap;
   logic indicator2_func, wake_frame_indicator, undervolt_flag, ptp_tx_event, ptp_rx_event, esd_event, irq_level;
   logic pins_input_forced, indicator2_in, clkout_pin, indicator2_out, indicator2_oe_n, transmit_error_input;
   logic rx_pull_up, rx_pull_down, tx_pull_up, tx_pull_down, q, x;
   logic [13:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, s;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [14:0] src_clks;
   logic [15:0] pin_levels, d, e;
   logic [4:0] rx_impedance, tx_impedance;
   logic [7:0] fn;
   logic [2:0] f;
   int fail_count = 0, checked = 0, cyc = 0, n;

   assign {irq_level, esd_event, ptp_rx_event, ptp_tx_event, undervolt_flag, wake_frame_indicator} = fn[7:2];
   assign indicator2_func = fn[0];
   copm_top DUT (.*);

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // Tests need under 1000 cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("mismatches %0d, checks %0d", fail_count, checked);
      if (fail_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] w);
      checked++;
      if (g !== w) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, w);
      end
   endtask

   task automatic rst(input logic b);
      receive_bit3_boot_strap <= b;
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   task automatic wr(input logic [11:0] i, input logic [15:0] v, output logic [1:0] rs);
      logic a, w;
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {16'h0000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      a = 1'b1;
      w = 1'b1;
      while (a || w) begin
         @(posedge aclk);
         a = a && !s_axi_awready;
         w = w && !s_axi_wready;
         s_axi_awvalid <= a;
         s_axi_wvalid <= w;
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] i, output logic [15:0] v, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      v = s_axi_rdata[15:0];
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rc(input logic [11:0] i, input logic [15:0] w, input logic [1:0] wr_resp);
      logic [15:0] v;
      logic [1:0] rs;
      rd(i, v, rs);
      chk(v, w);
      chk(rs, wr_resp);
   endtask

   function automatic logic [1:0] pl(input logic o, input logic [1:0] c);
      return (o && c == 2'h1) ? 2'b10 : ((o && c == 2'h2) ? 2'b01 : 2'b00);
   endfunction

   initial begin
      void'($urandom(32'hc461f8ac));
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {indicator2_daisy_strap, pins_input_forced, indicator2_in, src_clks, pin_levels, fn} = '0;
      ce = 1'b1;
      s_axi_wstrb = 4'hF;
      aresetn = 1'b0;
      receive_bit3_boot_strap = 1'b0;
      rst(1'b0);
      rc(CK, 16'h0001, OK);
      rc(PD, 16'h0000, OK);
      rc(ST, 16'h0000, OK);
      for (int i = 0; i < 12; i++) begin
         e = (i == 0) ? 16'hFFFF : 16'($urandom);
         wr(PD, e, r);
         rc(PD, e, OK);
         chk({rx_pull_up, rx_pull_down}, pl(e[13], e[15:14]));
         chk({tx_pull_up, tx_pull_down}, pl(e[10], e[12:11]));
         chk({rx_impedance, tx_impedance}, e[9:0]);
      end
      src_clks <= 15'($urandom);
      fn <= 8'($urandom);
      for (int i = 0; i < 24; i++) begin
         f = (i < 16) ? 3'h1 : 3'(i - 16);
         s = 4'(i);
         x = (s == 4'hF) ? 1'b0 : 1'($urandom);
         wr(CK, {8'h00, s, x, f}, r);
         rc(CK, {8'h00, s, x, f}, OK);
         repeat (3) @(posedge aclk);
         chk(clkout_pin, (f != 3'h1) ? fn[f] : ((s == 4'hF) ? 1'b0 : src_clks[s] ^ x));
      end
      for (int dv = 0; dv < 2; dv++) begin
         wr(CK, {7'h00, dv[0], 8'h01}, r);
         n = 0;
         for (int k = 0; k < 64; k++) begin
            @(posedge aclk);
            q = clkout_pin;
            src_clks[0] <= k[1];
            #1 n += int'(clkout_pin && !q);
         end
         chk(n >= (16 >> dv) - 1 && n <= (16 >> dv) + 1, 1'b1);
      end
      for (int b = 0; b < 4; b++) begin
         indicator2_in <= 1'($urandom);
         wr(CK, {b[0], 15'h0001}, r);
         chk({indicator2_oe_n, transmit_error_input}, {b[0], b[0] & indicator2_in});
         chk(indicator2_out, !b[0] && indicator2_func);
      end
      indicator2_daisy_strap <= 1'b1;
      wr(CK, 16'h0005, r);
      rc(CK, 16'h0000, OK);
      indicator2_daisy_strap <= 1'b0;
      e = 16'($urandom) | 16'h1000;
      pins_input_forced <= 1'b1;
      pin_levels <= e;
      repeat (3) @(posedge aclk);
      pins_input_forced <= 1'b0;
      pin_levels <= ~e;
      rc(ST, e & 16'hEFFF, OK);
      wr(ST, 16'hFFFF, r);
      chk(r, OK);
      rc(ST, e & 16'hEFFF, OK);
      rd(PD, d, r);
      wr(12'h000, 16'hFFFF, r);
      chk(r, copm_pkg::RESP_SLVERR);
      rc(12'h455, 16'h0000, copm_pkg::RESP_SLVERR);
      rc(PD, d, OK);
      rst(1'b1);
      rc(CK, 16'h0000, OK);
      rc(PD, 16'h0000, OK);
      report_and_stop();
   end
endmodule

`default_nettype wire
